// ===== rtl/afzt_pkg.sv
// constants shared by the arc-flash zone trip block
package afzt_pkg;
    localparam int NUM_ZONE = 4;
    localparam int NUM_CHAN = 4;
    localparam int NUM_SIG = 26;
    // positions of the 26 event-logged output signals
    localparam int SIG_LIGHT = 0;
    localparam int SIG_PRES = 4;
    localparam int SIG_BIN = 8;
    localparam int SIG_PH_START = 9;
    localparam int SIG_RES_START = 10;
    localparam int SIG_PH_BLK = 11;
    localparam int SIG_RES_BLK = 12;
    localparam int SIG_TRIP = 13;
    localparam int SIG_ZBLK = 17;
    localparam int SIG_SFAULT = 21;
    localparam int SIG_IOFAULT = 25;
    // operating mode codes, on after reset
    localparam logic [2:0] MODE_ON = 3'h1;
    localparam logic [2:0] MODE_BLOCKED = 3'h2;
    localparam logic [2:0] MODE_TEST = 3'h3;
    localparam logic [2:0] MODE_TEST_BLK = 3'h4;
    localparam logic [2:0] MODE_OFF = 3'h5;
    // force-status codes
    localparam logic [3:0] FORCE_NORMAL = 4'h0;
    localparam logic [3:0] FORCE_PH_BLK = 4'h1;
    localparam logic [3:0] FORCE_PH_START = 4'h2;
    localparam logic [3:0] FORCE_RES_BLK = 4'h3;
    localparam logic [3:0] FORCE_RES_START = 4'h4;
    localparam logic [3:0] FORCE_ZONE_BASE = 4'h5;
    // binary-input option per zone
    localparam logic [1:0] BIN_DISABLED = 2'h0;
    localparam logic [1:0] BIN_LIGHT_IN = 2'h1;
    localparam logic [1:0] BIN_CURRENT_IN = 2'h2;
    // time stamp tick
    localparam int CLK_PERIOD_NS = 4;
    localparam int STAMP_RES_NS = 1000000;
    localparam int STAMP_CYCLES = STAMP_RES_NS / CLK_PERIOD_NS;
    localparam logic [31:0] STAMP_RESET = 32'h0;
endpackage

// ===== rtl/afzt_zone_trip.sv
// arc-flash zone trip decision, sensor check, event log and counters
// Behaviour
// - every one of the 26 outputs logs an ON and an OFF event with a time stamp.
// - time stamps count whole milliseconds.
// - each zone counts its trips and its blocks, and each count clears on request.
// - the current condition rises only after the required number of samples exceed the limit.
// - the current condition is taken from phase or from residual current, as selected.
// - a zone with a current channel enabled trips only on overcurrent together with selected light, pressure or its binary input.
// - each zone has an enable and a per-channel light selection; any selected channel trips it.
// - pressure is selected per zone and per channel just as light is.
// - the mode is coded 1 on, 2 blocked, 3 test, 4 test/blocked, 5 off, on after reset.
// - force code 0 is normal, 1 to 4 force current states, 5 to 12 force zone states, if enabled.
// - each channel has an expected sensor count, zero meaning none.
// - a channel shows a configuration fault when the detected count differs from the expected.
// - mode, forcing and sensor counts are general settings, untouched by the setting group.
// - a picked-up zone trips when unblocked and shows blocked instead when blocked.
// - the binary input option is 0 off, 1 light-in alone, 2 current-in with a sensor channel.
`timescale 1ns/100ps
`default_nettype none
module afzt_zone_trip #(
    parameter int CNT_W = 16,
    parameter int SAMP_W = 4,
    parameter int STAMP_CYC = afzt_pkg::STAMP_CYCLES
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [3:0] LIGHT_IN,
    input wire logic [3:0] PRESSURE_IN,
    input wire logic ARC_BINARY_INPUT,
    input wire logic SAMPLE_STROBE,
    input wire logic PH_SAMPLE_OVER,
    input wire logic RES_SAMPLE_OVER,
    input wire logic [SAMP_W-1:0] REQ_SAMPLES,
    input wire logic CURR_SOURCE_RES,
    input wire logic PH_BLOCK_IN,
    input wire logic RES_BLOCK_IN,
    input wire logic [3:0] ZONE_BLOCK_IN,
    input wire logic [3:0] ZONE_EN,
    input wire logic [3:0] ZONE_PH_EN,
    input wire logic [3:0] ZONE_RES_EN,
    input wire logic [15:0] ZONE_LIGHT_SEL,
    input wire logic [15:0] ZONE_PRES_SEL,
    input wire logic [7:0] ZONE_BIN_MODE,
    input wire logic [2:0] LOGICAL_NODE_MODE,
    input wire logic FORCING_EN,
    input wire logic [3:0] FORCE_STATUS,
    input wire logic [7:0] SENSOR_EXPECT,
    input wire logic [7:0] SENSOR_DETECT,
    input wire logic [3:0] IO_UNITS_EXPECT,
    input wire logic [3:0] IO_UNITS_DETECT,
    input wire logic [7:0] COUNT_CLR,
    output logic [25:0] SIG_OUT,
    output logic EVT_VALID,
    output logic [4:0] EVT_ID,
    output logic EVT_ON,
    output logic [31:0] EVT_STAMP,
    output logic [4*CNT_W-1:0] TRIP_CNT,
    output logic [4*CNT_W-1:0] BLK_CNT
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    logic [20:0] sync1_reg;
    logic [20:0] sync2_reg;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_reg <= 21'h000000;
            sync2_reg <= 21'h000000;
        end else begin
            sync1_reg <= {IO_UNITS_DETECT, SENSOR_DETECT, ARC_BINARY_INPUT, PRESSURE_IN, LIGHT_IN};
            sync2_reg <= sync1_reg;
        end
    end
    logic [3:0] light_s;
    logic [3:0] pres_s;
    logic bin_s;
    assign light_s = sync2_reg[3:0];
    assign pres_s = sync2_reg[7:4];
    assign bin_s = sync2_reg[8];
    // detected counts come from the sensor side, so they are synchronised as well
    logic [7:0] det_s;
    logic [3:0] iod_s;
    assign det_s = sync2_reg[16:9];
    assign iod_s = sync2_reg[20:17];

    ////////////////////////////////////////////////////////////////////////////////
    // sample counter for the current condition, saturating
    logic [SAMP_W-1:0] samp_cnt_reg;
    logic [SAMP_W-1:0] samp_cnt_next;
    logic samp_over;
    logic cur_cond;
    always_comb begin
        samp_over = CURR_SOURCE_RES ? RES_SAMPLE_OVER : PH_SAMPLE_OVER;
        samp_cnt_next = samp_cnt_reg;
        if (SAMPLE_STROBE) begin
            if (!samp_over) begin
                samp_cnt_next = '0;
            end else if (samp_cnt_reg != '1) begin
                samp_cnt_next = samp_cnt_reg + 1'b1;
            end
        end
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            samp_cnt_reg <= '0;
        end else begin
            samp_cnt_reg <= samp_cnt_next;
        end
    end
    // a zero requirement is taken as one sample, so a quiet input never starts
    assign cur_cond = (samp_cnt_reg != '0) && (samp_cnt_reg >= REQ_SAMPLES);

    ////////////////////////////////////////////////////////////////////////////////
    // output signal decision
    logic [25:0] sig_reg;
    logic [25:0] sig_next;
    logic mode_blk;
    logic mode_off;
    logic frc;
    logic ph_start;
    logic res_start;
    logic [3:0] pick;
    always_comb begin
        // mode and force settings are general, no setting group selects them
        mode_blk = (LOGICAL_NODE_MODE == afzt_pkg::MODE_BLOCKED)
            || (LOGICAL_NODE_MODE == afzt_pkg::MODE_TEST_BLK);
        mode_off = (LOGICAL_NODE_MODE == afzt_pkg::MODE_OFF);
        frc = FORCING_EN && (FORCE_STATUS != afzt_pkg::FORCE_NORMAL);
        ph_start = !CURR_SOURCE_RES && cur_cond && !PH_BLOCK_IN;
        res_start = CURR_SOURCE_RES && cur_cond && !RES_BLOCK_IN;
        sig_next = '0;
        sig_next[afzt_pkg::SIG_LIGHT +: 4] = light_s;
        sig_next[afzt_pkg::SIG_PRES +: 4] = pres_s;
        sig_next[afzt_pkg::SIG_BIN] = bin_s;
        sig_next[afzt_pkg::SIG_PH_START] = ph_start
            || (frc && FORCE_STATUS == afzt_pkg::FORCE_PH_START);
        sig_next[afzt_pkg::SIG_RES_START] = res_start
            || (frc && FORCE_STATUS == afzt_pkg::FORCE_RES_START);
        sig_next[afzt_pkg::SIG_PH_BLK] = (!CURR_SOURCE_RES && PH_BLOCK_IN)
            || (frc && FORCE_STATUS == afzt_pkg::FORCE_PH_BLK);
        sig_next[afzt_pkg::SIG_RES_BLK] = (CURR_SOURCE_RES && RES_BLOCK_IN)
            || (frc && FORCE_STATUS == afzt_pkg::FORCE_RES_BLK);
        for (int z = 0; z < 4; z++) begin
            logic sens;
            logic bin_hit;
            logic cur_need;
            logic cur_ok;
            logic blk;
            sens = |(ZONE_LIGHT_SEL[z*4 +: 4] & light_s)
                || |(ZONE_PRES_SEL[z*4 +: 4] & pres_s);
            bin_hit = (ZONE_BIN_MODE[z*2 +: 2] == afzt_pkg::BIN_LIGHT_IN && bin_s)
                || (ZONE_BIN_MODE[z*2 +: 2] == afzt_pkg::BIN_CURRENT_IN
                && bin_s && sens);
            cur_need = ZONE_PH_EN[z] || ZONE_RES_EN[z];
            cur_ok = (ZONE_PH_EN[z] && ph_start) || (ZONE_RES_EN[z] && res_start);
            pick[z] = ZONE_EN[z] && (sens || bin_hit) && (!cur_need || cur_ok);
            blk = ZONE_BLOCK_IN[z] || mode_blk;
            sig_next[afzt_pkg::SIG_TRIP + z] = (pick[z] && !blk)
                || (frc && FORCE_STATUS == afzt_pkg::FORCE_ZONE_BASE + 4'(2*z));
            sig_next[afzt_pkg::SIG_ZBLK + z] = ((pick[z] && blk)
                || (frc && FORCE_STATUS == afzt_pkg::FORCE_ZONE_BASE + 4'(2*z+1)))
                && !sig_next[afzt_pkg::SIG_TRIP + z];
            sig_next[afzt_pkg::SIG_SFAULT + z] =
                SENSOR_EXPECT[z*2 +: 2] != det_s[z*2 +: 2];
        end
        sig_next[afzt_pkg::SIG_IOFAULT] = IO_UNITS_EXPECT != iod_s;
        if (mode_off) begin
            // off mode silences the whole function
            sig_next = '0;
        end
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sig_reg <= '0;
        end else begin
            sig_reg <= sig_next;
        end
    end
    assign SIG_OUT = sig_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // millisecond time stamp
    logic [31:0] pre_reg;
    logic [31:0] pre_next;
    logic [31:0] stamp_reg;
    logic [31:0] stamp_next;
    always_comb begin
        pre_next = pre_reg + 32'h1;
        stamp_next = stamp_reg;
        if (pre_reg == 32'(STAMP_CYC - 1)) begin
            pre_next = 32'h0;
            stamp_next = stamp_reg + 32'h1;
        end
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pre_reg <= 32'h0;
            stamp_reg <= afzt_pkg::STAMP_RESET;
        end else begin
            pre_reg <= pre_next;
            stamp_reg <= stamp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event log: one pending ON and OFF flag per signal, drained one per cycle
    logic [25:0] sig_d_reg;
    logic [25:0] pon_reg;
    logic [25:0] pon_next;
    logic [25:0] poff_reg;
    logic [25:0] poff_next;
    logic evt_valid_next;
    logic [4:0] evt_id_next;
    logic evt_on_next;
    logic [25:0] rise;
    logic [25:0] fall;
    always_comb begin
        rise = sig_reg & ~sig_d_reg;
        fall = ~sig_reg & sig_d_reg;
        evt_valid_next = 1'b0;
        evt_id_next = 5'h00;
        evt_on_next = 1'b0;
        pon_next = pon_reg;
        poff_next = poff_reg;
        for (int i = afzt_pkg::NUM_SIG - 1; i >= 0; i--) begin
            if (pon_reg[i] || poff_reg[i]) begin
                evt_valid_next = 1'b1;
                evt_id_next = 5'(i);
                // both pending: the older one is the one opposite the present level
                evt_on_next = pon_reg[i] && !(poff_reg[i] && sig_d_reg[i]);
            end
        end
        if (evt_valid_next) begin
            if (evt_on_next) begin
                pon_next[evt_id_next] = 1'b0;
            end else begin
                poff_next[evt_id_next] = 1'b0;
            end
        end
        // a new edge wins over the drain of the same flag
        pon_next = pon_next | rise;
        poff_next = poff_next | fall;
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sig_d_reg <= '0;
            pon_reg <= '0;
            poff_reg <= '0;
            EVT_VALID <= 1'b0;
            EVT_ID <= 5'h00;
            EVT_ON <= 1'b0;
            EVT_STAMP <= 32'h0;
        end else begin
            sig_d_reg <= sig_reg;
            pon_reg <= pon_next;
            poff_reg <= poff_next;
            EVT_VALID <= evt_valid_next;
            EVT_ID <= evt_id_next;
            EVT_ON <= evt_on_next;
            EVT_STAMP <= stamp_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-zone trip and block counters; a count on the clear cycle is kept
    genvar gz;
    generate
        for (gz = 0; gz < 4; gz++) begin : g_cnt
            logic [CNT_W-1:0] tcnt_reg;
            logic [CNT_W-1:0] tcnt_next;
            logic [CNT_W-1:0] bcnt_reg;
            logic [CNT_W-1:0] bcnt_next;
            always_comb begin
                tcnt_next = COUNT_CLR[gz] ? '0 : tcnt_reg;
                bcnt_next = COUNT_CLR[4+gz] ? '0 : bcnt_reg;
                if (rise[afzt_pkg::SIG_TRIP + gz]) begin
                    tcnt_next = tcnt_next + 1'b1;
                end
                if (rise[afzt_pkg::SIG_ZBLK + gz]) begin
                    bcnt_next = bcnt_next + 1'b1;
                end
            end
            always_ff @(posedge MCLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    tcnt_reg <= '0;
                    bcnt_reg <= '0;
                end else begin
                    tcnt_reg <= tcnt_next;
                    bcnt_reg <= bcnt_next;
                end
            end
            assign TRIP_CNT[gz*CNT_W +: CNT_W] = tcnt_reg;
            assign BLK_CNT[gz*CNT_W +: CNT_W] = bcnt_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_trip_blk_excl;
        @(posedge MCLK) disable iff (SYS_RST)
        (sig_reg[afzt_pkg::SIG_TRIP +: 4] & sig_reg[afzt_pkg::SIG_ZBLK +: 4]) == 4'h0;
    endproperty
    a_trip_blk_excl: assert property (p_trip_blk_excl) else $error("zone trips and blocks");
    property p_off_quiet;
        @(posedge MCLK) disable iff (SYS_RST)
        (LOGICAL_NODE_MODE == afzt_pkg::MODE_OFF) |=> (sig_reg == '0);
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("output active in off mode");
    property p_blk_mode;
        @(posedge MCLK) disable iff (SYS_RST)
        (LOGICAL_NODE_MODE == afzt_pkg::MODE_BLOCKED && !frc)
            |=> (sig_reg[afzt_pkg::SIG_TRIP +: 4] == 4'h0);
    endproperty
    a_blk_mode: assert property (p_blk_mode) else $error("trip in blocked mode");
    property p_sfault;
        @(posedge MCLK) disable iff (SYS_RST)
        (LOGICAL_NODE_MODE == afzt_pkg::MODE_ON && SENSOR_EXPECT[1:0] != det_s[1:0])
            |=> sig_reg[afzt_pkg::SIG_SFAULT];
    endproperty
    a_sfault: assert property (p_sfault) else $error("sensor fault missed");
    property p_stamp;
        @(posedge MCLK) disable iff (SYS_RST)
        (pre_reg != 32'(STAMP_CYC - 1)) |=> $stable(stamp_reg);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp moved before a millisecond");
    property p_trip_logged;
        @(posedge MCLK) disable iff (SYS_RST)
        $rose(sig_reg[afzt_pkg::SIG_TRIP])
            |-> ##[2:60] (EVT_VALID && EVT_ON && EVT_ID == 5'(afzt_pkg::SIG_TRIP));
    endproperty
    a_trip_logged: assert property (p_trip_logged) else $error("trip on event lost");
    property p_cnt_inc;
        @(posedge MCLK) disable iff (SYS_RST)
        (rise[afzt_pkg::SIG_TRIP] && !COUNT_CLR[0])
            |=> (TRIP_CNT[CNT_W-1:0] == $past(TRIP_CNT[CNT_W-1:0]) + 1'b1);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("trip count missed");
    property p_cnt_clr;
        @(posedge MCLK) disable iff (SYS_RST)
        (COUNT_CLR[4] && !rise[afzt_pkg::SIG_ZBLK]) |=> (BLK_CNT[CNT_W-1:0] == '0);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("block count not cleared");
    property p_cur_cond;
        @(posedge MCLK) disable iff (SYS_RST)
        (ph_start && !frc) |-> (samp_cnt_reg >= REQ_SAMPLES && samp_cnt_reg != '0);
    endproperty
    a_cur_cond: assert property (p_cur_cond) else $error("start before enough samples");
endmodule
`default_nettype wire

// ===== tb/afzt_sensor_model.sv
// behavioural arc sensor channels and current measurement facing the zone trip block
`timescale 1ns/100ps
`default_nettype none
module afzt_sensor_model (
    input wire logic clk,
    input wire logic strobe_en,
    input wire logic [22:0] cmd,
    output logic [3:0] light_pin,
    output logic [3:0] pres_pin,
    output logic bin_pin,
    output logic ph_ovr_pin,
    output logic res_ovr_pin,
    output logic [7:0] det_pin,
    output logic [3:0] io_det_pin,
    output logic strobe_pin
);
    logic [22:0] stage_reg = 23'h0;
    logic [1:0] phase_reg = 2'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // pins start quiet so nothing is unknown while reset is held
    initial begin
        {light_pin, pres_pin, bin_pin, ph_ovr_pin, res_ovr_pin, det_pin, io_det_pin} = 23'h0;
        strobe_pin = 1'b0;
    end
    // commands are taken on the rising edge so falling-edge writes by the bench never race
    always @(posedge clk) begin
        stage_reg <= cmd;
    end
    // pins move on the falling edge; no wiring test pulses are sent on the binary input
    always @(negedge clk) begin
        {light_pin, pres_pin, bin_pin, ph_ovr_pin, res_ovr_pin, det_pin, io_det_pin} <= stage_reg;
        phase_reg <= phase_reg + 2'h1;
        strobe_pin <= strobe_en && (phase_reg == 2'h3); // one current sample every 4 cycles
    end
endmodule
`default_nettype wire

// ===== tb/afzt_zone_trip_tb.sv
// self-checking bench for the arc-flash zone trip block
`timescale 1ns/100ps
`default_nettype none
module afzt_zone_trip_tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] light, pres, zone_blk, zone_en, zone_ph_en, zone_res_en, force_status, io_det;
    logic [3:0] req_samples, io_expect;
    logic bin, ph_over, res_over, strobe_en, curr_src_res, ph_blk, res_blk, forcing_en;
    logic [7:0] det, zone_bin_mode, sensor_expect, count_clr;
    logic [15:0] zone_light_sel, zone_pres_sel;
    logic [2:0] logical_node_mode;
    wire logic [3:0] light_pin, pres_pin, io_det_pin;
    wire logic [7:0] det_pin;
    wire logic bin_pin, ph_ovr_pin, res_ovr_pin, strobe_pin;
    logic [25:0] sig_out, prev;
    logic evt_valid, evt_on;
    logic [4:0] evt_id;
    logic [31:0] evt_stamp, r;
    logic [63:0] trip_cnt, blk_cnt;
    int n_fail = 0, num_checks = 0, seed = 32'hDA320817, cyc = 0;
    int exp_on[26], exp_off[26], got_on[26], got_off[26], tcnt[4], bcnt[4];
    ////////////////////////////////////////////////////////////////////////////////
    // short ms tick so stamps move within a short run
    afzt_sensor_model model (.clk(mclk), .strobe_en(strobe_en),
        .cmd({light, pres, bin, ph_over, res_over, det, io_det}), .light_pin(light_pin),
        .pres_pin(pres_pin), .bin_pin(bin_pin), .ph_ovr_pin(ph_ovr_pin),
        .res_ovr_pin(res_ovr_pin), .det_pin(det_pin), .io_det_pin(io_det_pin),
        .strobe_pin(strobe_pin));
    afzt_zone_trip #(.STAMP_CYC(10)) dut (.MCLK(mclk), .SYS_RST(sys_rst), .LIGHT_IN(light_pin),
        .PRESSURE_IN(pres_pin), .ARC_BINARY_INPUT(bin_pin), .SAMPLE_STROBE(strobe_pin),
        .PH_SAMPLE_OVER(ph_ovr_pin), .RES_SAMPLE_OVER(res_ovr_pin), .REQ_SAMPLES(req_samples),
        .CURR_SOURCE_RES(curr_src_res), .PH_BLOCK_IN(ph_blk), .RES_BLOCK_IN(res_blk),
        .ZONE_BLOCK_IN(zone_blk), .ZONE_EN(zone_en), .ZONE_PH_EN(zone_ph_en),
        .ZONE_RES_EN(zone_res_en), .ZONE_LIGHT_SEL(zone_light_sel), .ZONE_PRES_SEL(zone_pres_sel),
        .ZONE_BIN_MODE(zone_bin_mode), .LOGICAL_NODE_MODE(logical_node_mode), .FORCING_EN(forcing_en),
        .FORCE_STATUS(force_status), .SENSOR_EXPECT(sensor_expect), .SENSOR_DETECT(det_pin),
        .IO_UNITS_EXPECT(io_expect), .IO_UNITS_DETECT(io_det_pin), .COUNT_CLR(count_clr),
        .SIG_OUT(sig_out), .EVT_VALID(evt_valid), .EVT_ID(evt_id), .EVT_ON(evt_on),
        .EVT_STAMP(evt_stamp), .TRIP_CNT(trip_cnt), .BLK_CNT(blk_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    // clock at 4 ns
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic cmp_sig(input logic [25:0] got, input logic [25:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // expected steady outputs; current starts assume the sample count has long been met
    function automatic logic [25:0] exp_sig();
        logic [25:0] e;
        logic st_ph, st_res, sens, pick, blk;
        logic [1:0] m;
        st_ph = ph_over & ~ph_blk & ~curr_src_res;
        st_res = res_over & ~res_blk & curr_src_res;
        e = {1'b0, 4'h0, 8'h0, res_blk & curr_src_res, ph_blk & ~curr_src_res, st_res, st_ph,
            bin, pres, light};
        for (int z = 0; z < 4; z++) begin
            sens = |((light & zone_light_sel[z*4+:4]) | (pres & zone_pres_sel[z*4+:4]));
            m = zone_bin_mode[z*2+:2];
            pick = sens | (bin & (m == 2'h1)) | (bin & (m == 2'h2) & sens);
            if (zone_ph_en[z] | zone_res_en[z]) pick = sens & ((zone_ph_en[z] & st_ph) | (zone_res_en[z] & st_res));
            pick = pick & zone_en[z];
            blk = zone_blk[z] | (logical_node_mode == afzt_pkg::MODE_BLOCKED) | (logical_node_mode == afzt_pkg::MODE_TEST_BLK);
            e[13+z] = pick & ~blk;
            e[17+z] = pick & blk;
            e[21+z] = sensor_expect[z*2+:2] != det[z*2+:2];
        end
        e[25] = io_expect != io_det;
        if (logical_node_mode == afzt_pkg::MODE_OFF) e = 26'h0;
        return e;
    endfunction
    // bit that each force code drives high
    function automatic int fbit(input int code);
        if (code < 5) return (code == 1) ? 11 : (code == 2) ? 9 : (code == 3) ? 12 : 10;
        return ((code - 5) % 2) ? 17 + (code - 5) / 2 : 13 + (code - 5) / 2;
    endfunction
    task automatic quiet();
        {light, pres, bin, ph_over, res_over, det, io_det, zone_blk, zone_en} = '0;
        {zone_ph_en, zone_res_en, force_status, curr_src_res, ph_blk, res_blk, forcing_en} = '0;
        {zone_bin_mode, sensor_expect, count_clr, zone_light_sel, zone_pres_sel, io_expect} = '0;
        req_samples = 4'h1;
        strobe_en = 1'b1;
        logical_node_mode = afzt_pkg::MODE_ON;
    endtask
    // waits for strobes that carry an over-limit phase sample
    task automatic wait_ovr(input int n);
        repeat (n) begin
            @(posedge mclk);
            while (!(strobe_pin && ph_ovr_pin)) @(posedge mclk);
        end
    endtask
    // counts are compared once the event queue has drained
    task automatic check_events(input string name);
        repeat (60) @(negedge mclk);
        for (int i = 0; i < 26; i++) begin
            cmp_val(32'(got_on[i]), 32'(exp_on[i]), "on events");
            cmp_val(32'(got_off[i]), 32'(exp_off[i]), "off events");
        end
        for (int z = 0; z < 4; z++) begin
            cmp_val({16'h0, trip_cnt[z*16+:16]}, 32'(tcnt[z]), "trip count");
            cmp_val({16'h0, blk_cnt[z*16+:16]}, 32'(bcnt[z]), "blocked count");
        end
        $display("test %s done", name);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // monitor: edges of the outputs predict events and counts; stamps follow a 10-cycle ms
    always @(posedge mclk) begin
        if (sys_rst) begin
            prev = '0;
            cyc = 0;
        end else begin
            cyc++;
            for (int i = 0; i < 26; i++) begin
                if (sig_out[i] && !prev[i]) exp_on[i]++;
                if (!sig_out[i] && prev[i]) exp_off[i]++;
            end
            // a rise in the clear cycle still counts once
            for (int z = 0; z < 4; z++) begin
                if (count_clr[z]) tcnt[z] = 0;
                if (count_clr[4+z]) bcnt[z] = 0;
                if (sig_out[13+z] && !prev[13+z]) tcnt[z]++;
                if (sig_out[17+z] && !prev[17+z]) bcnt[z]++;
            end
            if (evt_valid === 1'b1) begin
                if (evt_on) got_on[evt_id]++;
                else got_off[evt_id]++;
                cmp_val({31'h0, evt_stamp + 1 >= cyc / 10 && evt_stamp <= cyc / 10 + 1}, 32'h1, "stamp");
            end
            prev = sig_out;
        end
    end
    // hang guard, well past the some 1600 cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        quiet();
        repeat (10) @(negedge mclk);
        sys_rst = 1'b0;
        cmp_sig(sig_out, 26'h0, "after reset");
        // light on channel one trips zone one three edges after the pin moves
        zone_en = 4'h1;
        zone_light_sel = 16'h0001;
        light = 4'h1;
        @(negedge mclk);
        repeat (2) @(negedge mclk);
        cmp_val({31'h0, sig_out[afzt_pkg::SIG_TRIP]}, 32'h0, "trip too early");
        @(negedge mclk);
        cmp_val({31'h0, sig_out[afzt_pkg::SIG_TRIP]}, 32'h1, "trip");
        light = 4'h0;
        check_events("walk");
        // current gate: needs three over-limit samples as well as light
        quiet();
        req_samples = 4'h3;
        {zone_en, zone_ph_en, zone_light_sel, light} = {4'h1, 4'h1, 16'h0001, 4'h1};
        repeat (20) @(negedge mclk);
        cmp_sig(sig_out, exp_sig(), "light without current");
        ph_over = 1'b1;
        wait_ovr(2);
        repeat (2) @(negedge mclk);
        cmp_val({31'h0, sig_out[afzt_pkg::SIG_PH_START]}, 32'h0, "start after two");
        wait_ovr(1);
        repeat (3) @(negedge mclk);
        cmp_val({31'h0, sig_out[afzt_pkg::SIG_PH_START]}, 32'h1, "start after three");
        repeat (4) @(negedge mclk);
        cmp_sig(sig_out, exp_sig(), "light with current");
        quiet();
        check_events("current");
        // every force code, honoured only while forcing is enabled
        forcing_en = 1'b1;
        for (int c = 1; c <= 12; c++) begin
            force_status = 4'(c);
            repeat (4) @(negedge mclk);
            cmp_val({31'h0, sig_out[fbit(c)]}, 32'h1, "forced state");
        end
        forcing_en = 1'b0;
        repeat (4) @(negedge mclk);
        cmp_sig(sig_out, exp_sig(), "forcing off");
        force_status = 4'h0;
        check_events("force");
        // random settings, every mode, blocks and sensor counts
        for (int k = 0; k < 40; k++) begin
            r = $random(seed);
            {curr_src_res, zone_blk, zone_en, req_samples, force_status} = r[20:0];
            {light, pres, bin, ph_over, res_over, ph_blk, res_blk} = r[31:19];
            // at most three samples, so the count is met within the settle time
            req_samples = {2'h0, req_samples[1:0]};
            r = $random(seed);
            {zone_light_sel, zone_pres_sel} = r;
            r = $random(seed);
            {zone_bin_mode, zone_ph_en, sensor_expect, det, io_expect} = {r, 4'h0};
            if (r[0]) det = sensor_expect;
            io_det = {2'h0, r[2:1]};
            io_expect = {2'h0, r[4:3]};
            zone_res_en = curr_src_res ? zone_ph_en : 4'h0;
            zone_ph_en = curr_src_res ? 4'h0 : zone_ph_en;
            for (int z = 0; z < 4; z++) begin
                if (zone_ph_en[z] | zone_res_en[z]) zone_bin_mode[z*2+:2] = afzt_pkg::BIN_DISABLED;
                if (zone_bin_mode[z*2+:2] == afzt_pkg::BIN_CURRENT_IN) bin = 1'b1;
            end
            logical_node_mode = 3'(1 + ($unsigned($random(seed)) % 5));
            repeat (30) @(negedge mclk);
            cmp_sig(sig_out, exp_sig(), "random settings");
        end
        quiet();
        check_events("random");
        // clearing every count
        count_clr = 8'hFF;
        @(negedge mclk);
        count_clr = 8'h00;
        check_events("clear");
        close_out();
    end
endmodule
`default_nettype wire
